// ===== logic/dbc_defs.vh
// Constants shared by the DDR burst and command timing block
`ifndef DBC_DEFS_VH
`define DBC_DEFS_VH

// ----------------------------------------
// Command codes on {row strobe, column strobe, write enable}, active low
// ----------------------------------------
`define DBC_CMD_ACT 3'h3
`define DBC_CMD_READ 3'h5
`define DBC_CMD_WRITE 3'h4
`define DBC_CMD_PRE 3'h2
`define DBC_CMD_BST 3'h6

// ----------------------------------------
// Address and data layout
// ----------------------------------------
`define DBC_ADDR_W 13
`define DBC_AP_BIT 10
`define DBC_BANKS 4
`define DBC_DQ_W 16
`define DBC_BYTE_W 8

// ----------------------------------------
// Read latency settings and their delay in half clocks
// ----------------------------------------
`define DBC_RL_2 2'h0
`define DBC_RL_2P5 2'h1
`define DBC_RL_3 2'h2
`define DBC_HALF_RL_2 3'h4
`define DBC_HALF_RL_2P5 3'h5
`define DBC_HALF_RL_3 3'h6
`define DBC_PIPE_DEPTH 6

// ----------------------------------------
// Burst length settings and lengths
// ----------------------------------------
`define DBC_BL_SEL_2 2'h1
`define DBC_BL_SEL_4 2'h2
`define DBC_BL_SEL_8 2'h3
`define DBC_BL_2 4'h2
`define DBC_BL_4 4'h4
`define DBC_BL_8 4'h8

// ----------------------------------------
// Write staging FIFO
// ----------------------------------------
`define DBC_FIFO_DEPTH 16

`endif

// ===== logic/dbc_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module dbc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire srst,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign inReady = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = store[rdPtr_q];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always @(posedge clk) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
			end
			if (push & ~pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop & ~push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ===== logic/dbc_core.v
// Device side of a four-bank DDR memory: command decode, read and write bursts
`timescale 1ns/1ns
`default_nettype none
`include "dbc_defs.vh"

// Summary of operation
// - First read element leaves after 2, 2.5 or 3 clocks, on both edges.
// - Remaining burst elements follow in programmed order after the first column.
// - Length four reads concatenate back to back; length eight is interrupted.
// - Random reads to open rows in any bank; new read cuts running burst.
// - Burst stop ends read of eight after four elements, latency respected.
// - Write with address bit ten low keeps the row open afterwards.
// - Random writes to any bank; following write truncates running burst.
module dbc_core #(
	parameter ROW_W = 2,
	parameter COL_W = 4,
	parameter FIFO_DEPTH = `DBC_FIFO_DEPTH,
	parameter FIFO_AW = 4
) (
	input wire clk,
	input wire srst,
	input wire linkClk,
	input wire csN,
	input wire rasN,
	input wire casN,
	input wire weN,
	input wire [1:0] bankAddr,
	input wire [`DBC_ADDR_W-1:0] addr,
	input wire [`DBC_DQ_W-1:0] dqIn,
	input wire dqsIn,
	input wire upperByteWriteMask,
	input wire lowerByteWriteMask,
	input wire [1:0] readLatencySetting,
	input wire [1:0] burstLenSel,
	input wire burstInterleave,
	output reg [`DBC_DQ_W-1:0] dqOut_q,
	output reg dqOe_q,
	output reg dqsOut_q,
	output reg dqsOe_q,
	output reg writeDropped_q,
	output reg accessError_q
);
	localparam SYNC_W = 28 + `DBC_DQ_W;
	localparam ENT_W = 5 + ROW_W + COL_W;
	localparam MEM_AW = 2 + ROW_W + COL_W;
	localparam WORD_W = MEM_AW + `DBC_DQ_W + 2;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [3:0] blLen;
		input [1:0] sel;
		begin
			case (sel)
				`DBC_BL_SEL_2: blLen = `DBC_BL_2;
				`DBC_BL_SEL_8: blLen = `DBC_BL_8;
				default: blLen = `DBC_BL_4;
			endcase
		end
	endfunction

	function [2:0] latHalf;
		input [1:0] sel;
		begin
			case (sel)
				`DBC_RL_2: latHalf = `DBC_HALF_RL_2;
				`DBC_RL_2P5: latHalf = `DBC_HALF_RL_2P5;
				default: latHalf = `DBC_HALF_RL_3;
			endcase
		end
	endfunction

	// Column of element idx: low bits wrap inside the burst, sequential or interleaved
	function [COL_W-1:0] burstCol;
		input [COL_W-1:0] col;
		input [3:0] idx;
		input [1:0] sel;
		input ilv;
		reg [COL_W-1:0] mask;
		reg [COL_W-1:0] step;
		begin
			mask = {{(COL_W-4){1'b0}}, blLen(sel) - 4'h1};
			step = {{(COL_W-4){1'b0}}, idx};
			if (ilv) begin
				burstCol = (col & ~mask) | ((col ^ step) & mask);
			end else begin
				burstCol = (col & ~mask) | ((col + step) & mask);
			end
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [SYNC_W-1:0] pinMeta_q;
	reg [SYNC_W-1:0] pinSync_q;
	reg clkPrev_q;
	reg dqsPrev_q;
	wire sClk, sDqs, sCsN, sRasN, sCasN, sWeN, sUdm, sLdm, sIlv;
	wire [1:0] sBa, sRl, sBl;
	wire [`DBC_ADDR_W-1:0] sAddr;
	wire [`DBC_DQ_W-1:0] sDq;

	always @(posedge clk) begin
		pinMeta_q <= {linkClk, dqsIn, csN, rasN, casN, weN, bankAddr, addr, dqIn,
			upperByteWriteMask, lowerByteWriteMask, readLatencySetting, burstLenSel, burstInterleave};
		pinSync_q <= pinMeta_q;
		clkPrev_q <= sClk;
		dqsPrev_q <= sDqs;
	end

	assign {sClk, sDqs, sCsN, sRasN, sCasN, sWeN, sBa, sAddr, sDq, sUdm, sLdm, sRl, sBl, sIlv} = pinSync_q;

	wire linkRise = sClk & ~clkPrev_q;
	wire linkEdge = sClk ^ clkPrev_q;
	wire dqsRise = sDqs & ~dqsPrev_q;
	wire dqsEdge = sDqs ^ dqsPrev_q;
	wire cmdValid = linkRise & ~sCsN;
	wire [2:0] cmd = {sRasN, sCasN, sWeN};
	wire [3:0] curBl = blLen(sBl);
	wire [2:0] curLat = latHalf(sRl);

	// ----------------------------------------
	// Bank state, burst state and storage
	// ----------------------------------------
	reg [`DBC_BANKS-1:0] bankOpen_q;
	reg [ROW_W-1:0] openRow_q [0:`DBC_BANKS-1];
	reg [ENT_W-1:0] pipe_q [0:`DBC_PIPE_DEPTH-1];
	reg [`DBC_DQ_W-1:0] mem [0:(1<<MEM_AW)-1];
	reg rdBusy_q, rdAp_q;
	reg [3:0] rdIdx_q;
	reg [1:0] rdBank_q;
	reg [ROW_W-1:0] rdRow_q;
	reg [COL_W-1:0] rdCol_q;
	reg [3:0] wrLeft_q, wrIdx_q;
	reg wrArmed_q, wrAp_q;
	reg [1:0] wrBank_q;
	reg [ROW_W-1:0] wrRow_q;
	reg [COL_W-1:0] wrCol_q;
	integer i;

	// Pipe entry: valid, stop, auto precharge, bank, row, column
	wire [ENT_W-1:0] tapEnt = pipe_q[curLat - 3'h1];
	wire [ENT_W-1:0] preEnt = pipe_q[curLat - 3'h2];
	wire tapValid = tapEnt[ENT_W-1];
	wire tapStop = tapEnt[ENT_W-2];
	wire tapAp = tapEnt[ENT_W-3];
	wire [1:0] tapBank = tapEnt[ROW_W+COL_W+1:ROW_W+COL_W];
	wire [ROW_W-1:0] tapRow = tapEnt[ROW_W+COL_W-1:COL_W];
	wire [COL_W-1:0] tapCol = tapEnt[COL_W-1:0];
	wire bankHit = bankOpen_q[sBa];
	wire [ROW_W-1:0] sRow = sAddr[ROW_W-1:0];
	wire [COL_W-1:0] sCol = sAddr[COL_W-1:0];

	wire [`DBC_DQ_W-1:0] firstData = mem[{tapBank, tapRow, burstCol(tapCol, 4'h0, sBl, sIlv)}];
	wire [`DBC_DQ_W-1:0] nextData = mem[{rdBank_q, rdRow_q, burstCol(rdCol_q, rdIdx_q, sBl, sIlv)}];

	// ----------------------------------------
	// Write staging FIFO; draining stalls while read data is out
	// ----------------------------------------
	wire fifoInReady, fifoOutValid;
	wire [WORD_W-1:0] fifoOut;
	wire wrCapture = dqsEdge & (dqsRise | wrArmed_q) & (wrLeft_q != 4'h0);
	wire [WORD_W-1:0] wrWord = {wrBank_q, wrRow_q, burstCol(wrCol_q, wrIdx_q, sBl, sIlv), sDq, sUdm, sLdm};

	dbc_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) wrFifo (
		.clk(clk),
		.srst(srst),
		.inValid(wrCapture),
		.inReady(fifoInReady),
		.inData(wrWord),
		.outValid(fifoOutValid),
		.outReady(~dqOe_q),
		.outData(fifoOut)
	);

	wire drain = fifoOutValid & ~dqOe_q;
	wire [MEM_AW-1:0] drainAddr = fifoOut[WORD_W-1:`DBC_DQ_W+2];

	// Masked bytes keep their old contents
	always @(posedge clk) begin
		if (drain & ~fifoOut[1]) begin
			mem[drainAddr][`DBC_DQ_W-1:`DBC_BYTE_W] <= fifoOut[`DBC_DQ_W+1:`DBC_BYTE_W+2];
		end
		if (drain & ~fifoOut[0]) begin
			mem[drainAddr][`DBC_BYTE_W-1:0] <= fifoOut[`DBC_BYTE_W+1:2];
		end
	end

	// ----------------------------------------
	// Command, burst and bank control
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			bankOpen_q <= {`DBC_BANKS{1'b0}};
			for (i = 0; i < `DBC_BANKS; i = i + 1) begin
				openRow_q[i] <= {ROW_W{1'b0}};
			end
			for (i = 0; i < `DBC_PIPE_DEPTH; i = i + 1) begin
				pipe_q[i] <= {ENT_W{1'b0}};
			end
			rdBusy_q <= 1'b0;
			rdAp_q <= 1'b0;
			rdIdx_q <= 4'h0;
			rdBank_q <= 2'h0;
			rdRow_q <= {ROW_W{1'b0}};
			rdCol_q <= {COL_W{1'b0}};
			wrLeft_q <= 4'h0;
			wrIdx_q <= 4'h0;
			wrArmed_q <= 1'b0;
			wrAp_q <= 1'b0;
			wrBank_q <= 2'h0;
			wrRow_q <= {ROW_W{1'b0}};
			wrCol_q <= {COL_W{1'b0}};
			dqOut_q <= {`DBC_DQ_W{1'b0}};
			dqOe_q <= 1'b0;
			dqsOut_q <= 1'b0;
			dqsOe_q <= 1'b0;
			writeDropped_q <= 1'b0;
			accessError_q <= 1'b0;
		end else begin
			writeDropped_q <= wrCapture & ~fifoInReady;
			accessError_q <= cmdValid & ~bankHit & ((cmd == `DBC_CMD_READ) | (cmd == `DBC_CMD_WRITE));

			if (wrCapture) begin
				wrArmed_q <= 1'b1;
				wrIdx_q <= wrIdx_q + 4'h1;
				wrLeft_q <= wrLeft_q - 4'h1;
				if (wrLeft_q == 4'h1 && wrAp_q) begin
					bankOpen_q[wrBank_q] <= 1'b0;
				end
			end

			// Read path advances on both link clock edges
			if (linkEdge) begin
				for (i = 1; i < `DBC_PIPE_DEPTH; i = i + 1) begin
					pipe_q[i] <= pipe_q[i-1];
				end
				pipe_q[0] <= {ENT_W{1'b0}};
				if (tapValid && !tapStop) begin
					if (rdBusy_q && rdAp_q) begin
						bankOpen_q[rdBank_q] <= 1'b0;
					end
					rdBusy_q <= 1'b1;
					rdIdx_q <= 4'h1;
					rdAp_q <= tapAp;
					rdBank_q <= tapBank;
					rdRow_q <= tapRow;
					rdCol_q <= tapCol;
					dqOut_q <= firstData;
					dqOe_q <= 1'b1;
					dqsOut_q <= 1'b1;
					dqsOe_q <= 1'b1;
				end else if (tapValid && tapStop) begin
					rdBusy_q <= 1'b0;
					dqOe_q <= 1'b0;
					dqsOe_q <= 1'b0;
					dqsOut_q <= 1'b0;
				end else if (rdBusy_q && rdIdx_q != curBl) begin
					rdIdx_q <= rdIdx_q + 4'h1;
					dqOut_q <= nextData;
					dqsOut_q <= ~rdIdx_q[0];
				end else begin
					if (rdBusy_q && rdAp_q) begin
						bankOpen_q[rdBank_q] <= 1'b0;
					end
					rdBusy_q <= 1'b0;
					dqOe_q <= 1'b0;
					// Read preamble holds strobe low one edge early
					dqsOe_q <= preEnt[ENT_W-1] & ~preEnt[ENT_W-2];
					dqsOut_q <= 1'b0;
				end
			end

			if (cmdValid) begin
				case (cmd)
					`DBC_CMD_ACT: begin
						bankOpen_q[sBa] <= 1'b1;
						openRow_q[sBa] <= sRow;
					end
					`DBC_CMD_PRE: begin
						if (sAddr[`DBC_AP_BIT]) begin
							bankOpen_q <= {`DBC_BANKS{1'b0}};
						end else begin
							bankOpen_q[sBa] <= 1'b0;
						end
					end
					`DBC_CMD_READ: begin
						if (bankHit) begin
							pipe_q[0] <= {1'b1, 1'b0, sAddr[`DBC_AP_BIT], sBa, openRow_q[sBa], sCol};
						end
					end
					`DBC_CMD_BST: begin
						pipe_q[0] <= {1'b1, 1'b1, 1'b0, 2'h0, {ROW_W{1'b0}}, {COL_W{1'b0}}};
					end
					`DBC_CMD_WRITE: begin
						if (bankHit) begin
							wrLeft_q <= curBl;
							wrIdx_q <= 4'h0;
							wrArmed_q <= 1'b0;
							wrAp_q <= sAddr[`DBC_AP_BIT];
							wrBank_q <= sBa;
							wrRow_q <= openRow_q[sBa];
							wrCol_q <= sCol;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// ===== test/dbc_core_props.sv
// Concurrent checks on the read strobe, data enables and error pulse of the core
`timescale 1ns/1ns
`default_nettype none
`include "dbc_defs.vh"

module dbc_core_props (
	input wire clk,
	input wire srst,
	input wire linkClk,
	input wire csN,
	input wire rasN,
	input wire casN,
	input wire weN,
	input wire dqOe_q,
	input wire dqsOut_q,
	input wire dqsOe_q,
	input wire accessError_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------
	// Read output framing and access error pulse
	// ----------------------------------------
	AST_RESET_QUIET: assert property ($fell(srst) |-> !dqOe_q && !dqsOe_q && !accessError_q)
		else $error("outputs active after reset");
	AST_DATA_NEEDS_STROBE: assert property (dqOe_q |-> dqsOe_q)
		else $error("data driven without strobe");
	AST_PREAMBLE_LOW: assert property ($rose(dqsOe_q) |-> !dqsOut_q && !dqOe_q)
		else $error("strobe preamble not low");
	AST_FIRST_EVEN: assert property ($rose(dqOe_q) |-> dqsOut_q)
		else $error("first element strobe not high");
	AST_HALF_STANDS: assert property (dqOe_q && $changed(dqsOut_q) |=> $stable(dqsOut_q)[*3])
		else $error("element shorter than a half link clock");
	AST_ENDS_TOGETHER: assert property ($fell(dqOe_q) |-> $fell(dqsOe_q))
		else $error("strobe and data enables end apart");
	AST_ERR_PULSE: assert property (accessError_q |=> !accessError_q[*3])
		else $error("access error not a single pulse");
	AST_READ_ANSWER: assert property ($rose(linkClk) && !csN && {rasN, casN, weN} == `DBC_CMD_READ
		|-> ##[1:32] (dqOe_q || accessError_q))
		else $error("read got neither data nor error");
endmodule

`default_nettype wire

// ===== test/dbc_ctl_model.sv
// Controller model: free running memory clock, commands and write strobes
`timescale 1ns/1ns
`default_nettype none
`include "dbc_defs.vh"

module dbc_ctl_model (
	input wire logic clk,
	output logic linkClk,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [1:0] bankAddr,
	output logic [12:0] addr,
	output logic [15:0] dqIn,
	output logic dqsIn
);
	logic [2:0] ph = 3'h0;
	// Memory clock runs free, eight system clocks a period
	assign linkClk = !ph[2];
	always @(posedge clk) ph <= ph + 3'h1;
	initial begin
		csN = 1'b1;
		{rasN, casN, weN} = 3'h7;
		bankAddr = 2'h0;
		addr = 13'h0;
		dqIn = 16'h0;
		dqsIn = 1'b0;
	end
	task waitPh(input logic [2:0] p);
		@(posedge clk);
		#1;
		while (ph !== p) begin
			@(posedge clk);
			#1;
		end
	endtask
	// one device; command held a whole link period around its rise
	task issue(input logic [2:0] code, input logic [1:0] b, input logic [12:0] a);
		waitPh(3'h4);
		csN = 1'b0;
		{rasN, casN, weN} = code;
		bankAddr = b;
		addr = a;
	endtask
	task idle();
		waitPh(3'h4);
		csN = 1'b1;
		{rasN, casN, weN} = 3'h7;
		addr = ~addr;
	endtask
	// data set one cycle before each strobe edge
	task write(input logic [1:0] b, input logic [3:0] c, input logic [127:0] d, input int n);
		issue(`DBC_CMD_WRITE, b, {9'h0, c});
		idle();
		for (int i = 0; i < n; i++) begin
			waitPh(i[0] ? 3'h3 : 3'h7);
			dqIn = d[16*i +: 16];
			waitPh(i[0] ? 3'h4 : 3'h0);
			dqsIn = !i[0];
		end
		waitPh(3'h3);
		dqIn = ~dqIn;
	endtask
endmodule

`default_nettype wire

// ===== test/test_ddr_burst_command_timing.sv
// Self-checking bench for the DDR burst and command timing core
`timescale 1ns/1ns
`default_nettype none
`include "dbc_defs.vh"

module test_ddr_burst_command_timing;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic linkClk, csN, rasN, casN, weN, dqsIn, dqOe_q, dqsOut_q, dqsOe_q, accessError_q, wrDrop;
	int drops = 0;
	logic [1:0] bankAddr;
	logic [1:0] rlSel = 2'h0;
	logic [1:0] blSel = 2'h3;
	logic ilv = 1'b0;
	logic prevOe = 1'b0;
	logic prevDqs = 1'b0;
	logic [12:0] addr;
	logic [15:0] dqIn, dqOut_q;
	logic [15:0] mem [64];
	logic [15:0] expQ [$];
	int numErrors = 0, samplesChecked = 0, cyc = 0, runs = 0, runLen = 0, lastLen = 0, riseCyc = 0, errs = 0;
	int t0, n;
	always #50 clk = ~clk;
	dbc_ctl_model ctl (.clk(clk), .linkClk(linkClk), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
		.bankAddr(bankAddr), .addr(addr), .dqIn(dqIn), .dqsIn(dqsIn));
	dbc_core uut (.clk(clk), .srst(srst), .linkClk(linkClk), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
		.bankAddr(bankAddr), .addr(addr), .dqIn(dqIn), .dqsIn(dqsIn), .upperByteWriteMask(1'b0),
		.lowerByteWriteMask(1'b0), .readLatencySetting(rlSel), .burstLenSel(blSel), .burstInterleave(ilv),
		.dqOut_q(dqOut_q), .dqOe_q(dqOe_q), .dqsOut_q(dqsOut_q), .dqsOe_q(dqsOe_q), .writeDropped_q(wrDrop),
		.accessError_q(accessError_q));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finishTest();
		$display("checks %0d mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Output watcher: a new element starts when the strobe turns while driving
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (accessError_q === 1'b1) errs++;
		if (wrDrop !== 1'b0) drops++;
		if (dqOe_q === 1'b1) begin
			runLen++;
			if (!prevOe) riseCyc = cyc;
			if (!prevOe || dqsOut_q !== prevDqs) begin
				if (expQ.size() == 0) begin
					numErrors++;
					$display("BAD read element expected none seen %h", dqOut_q);
				end else chk("read element", dqOut_q, expQ.pop_front());
			end
		end else if (prevOe) begin
			runs++;
			lastLen = runLen;
			runLen = 0;
		end
		prevOe = dqOe_q;
		prevDqs = dqsOut_q;
	end
	initial begin
		#3000000;
		numErrors++;
		$display("BAD watchdog expected done seen hang");
		finishTest();
	end

	function automatic logic [3:0] colOf(input logic [3:0] c, input int i, input int bl);
		logic [3:0] m;
		m = 4'(bl - 1);
		colOf = ilv ? ((c & ~m) | ((c ^ 4'(i)) & m)) : ((c & ~m) | ((c + 4'(i)) & m));
	endfunction
	// Settings are synced levels, so change them only between idle link periods
	task setMode(input logic [1:0] r, input logic [1:0] b);
		ctl.idle();
		rlSel = r;
		blSel = b;
		ilv = 1'($urandom);
		ctl.idle();
	endtask
	task rd(input logic [1:0] b, input logic [3:0] c, input int k);
		for (int i = 0; i < k; i++) expQ.push_back(mem[{b, colOf(c, i, 1 << blSel)}]);
		ctl.issue(`DBC_CMD_READ, b, {9'h0, c});
		t0 = cyc;
		ctl.idle();
	endtask
	task wr(input logic [1:0] b, input logic [3:0] c);
		logic [127:0] d;
		for (int i = 0; i < 8; i++) begin
			d[16*i +: 16] = 16'($urandom);
			mem[{b, colOf(c, i, 8)}] = d[16*i +: 16];
		end
		ctl.write(b, c, d, 8);
	endtask
	task waitRun(input int target);
		for (int w = 0; w < 400 && runs < target; w++) @(posedge clk);
		#1;
	endtask
	task closedRead(input logic [1:0] b);
		n = errs;
		ctl.issue(`DBC_CMD_READ, b, 13'h3);
		ctl.idle();
		ctl.idle();
		chk("closed bank error", errs - n, 1);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h1258));
		repeat (3) @(posedge clk);
		#1 srst = 1'b0;
		setMode(2'h0, 2'h3);
		closedRead(2'h2);
		$display("test closed bank done");
		// banks 0 and 1 opened once; only bank 0 closed, long after
		for (int b = 0; b < 2; b++) begin
			ctl.issue(`DBC_CMD_ACT, 2'(b), 13'h1);
			ctl.idle();
			wr(2'(b), 4'h0);
			wr(2'(b), 4'h8);
		end
		// two idle link clocks before the latency reads
		ctl.idle();
		ctl.idle();
		chk("write drops", drops, 0);
		$display("test writes done");
		for (int r = 0; r < 3; r++) begin
			setMode(2'(r), 2'h2);
			n = runs;
			rd(2'h0, 4'(5 + r), 4);
			waitRun(n + 1);
			// Command half period, two to three link clocks, sync and edge detect, watcher lag
			chk("read latency", riseCyc - t0, 24 + 4 * r);
			chk("burst cycles", lastLen, 16);
		end
		$display("test latencies done");
		n = runs;
		rd(2'h0, 4'hE, 4);
		rd(2'h1, 4'h3, 4);
		waitRun(n + 1);
		chk("concat cycles", lastLen, 32);
		setMode(2'h0, 2'h3);
		n = runs;
		rd(2'h1, 4'h9, 4);
		rd(2'h0, 4'h2, 8);
		waitRun(n + 1);
		chk("interrupt cycles", lastLen, 48);
		n = runs;
		rd(2'h0, 4'h4, 4);
		ctl.issue(`DBC_CMD_BST, 2'h0, 13'h0);
		ctl.idle();
		waitRun(n + 1);
		chk("stop cycles", lastLen, 16);
		// write only after the read was stopped
		wr(2'h1, 4'h0);
		chk("write drops", drops, 0);
		setMode(2'h1, 2'h1);
		n = runs;
		rd(2'h1, 4'hB, 2);
		rd(2'h0, 4'h3, 2);
		waitRun(n + 2);
		chk("short burst cycles", lastLen, 8);
		$display("test streams done");
		// precharge well after the read burst
		ctl.issue(`DBC_CMD_PRE, 2'h0, 13'h0);
		ctl.idle();
		closedRead(2'h0);
		chk("pending reads", expQ.size(), 0);
		$display("test precharge done");
		finishTest();
	end
endmodule

bind dbc_core dbc_core_props props (.clk(clk), .srst(srst), .linkClk(linkClk), .csN(csN), .rasN(rasN),
	.casN(casN), .weN(weN), .dqOe_q(dqOe_q), .dqsOut_q(dqsOut_q), .dqsOe_q(dqsOe_q),
	.accessError_q(accessError_q));

`default_nettype wire
